// [hdl/tar_regs.svh]
// opcodes, field positions, reset values and ratio divider constants
`ifndef TAR_REGS_SVH
`define TAR_REGS_SVH
`define TAR_OP_CTRL_WR 8'hFF
`define TAR_OP_CTRL_RD 8'h7F
`define TAR_OP_WVR_RD 8'hC4
`define TAR_CTRL_ALARM_ARM_BIT 9
`define TAR_CTRL_TAMPER_ARM_BIT 8
`define TAR_CTRL_RESET 16'h0000
`define TAR_RESULT_RESET 16'h0000
`define TAR_RATIO_FRAC_BITS 7
`define TAR_RATIO_MAX 8'hFF
`define TAR_DIV_STEPS 4'h8
`endif

// [hdl/tar_pkg.sv]
// types shared by the tamper/alarm arm and ratio result block
package tar_pkg;
  typedef struct packed {
    logic valid;
    logic [7:0] opcode;
    logic [15:0] wdata;
  } tar_cmd_t;
  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } tar_rsp_t;
  typedef struct packed {
    logic done;
    logic [15:0] t1_width;
    logic [15:0] t2_width;
    logic [15:0] ideal_half_period;
  } tar_meas_t;
  typedef struct packed {
    logic tick;
    logic [7:0] hours;
    logic [7:0] minutes;
    logic [7:0] alarm_hours;
    logic [7:0] alarm_minutes;
  } tar_rtc_t;
  typedef enum logic [1:0] {
    TAR_DIV_IDLE = 2'b00,
    TAR_DIV_RUN = 2'b01,
    TAR_DIV_DONE = 2'b11
  } tar_div_state_t;
  typedef struct packed {
    tar_div_state_t state;
    logic [3:0] step;
    logic [16:0] rem;
    logic [15:0] den;
    logic [7:0] quot;
  } tar_div_st_t;
endpackage

// [hdl/tar_ratio_div.sv]
// sequential fixed-point ratio divider, 1 integer and 7 fraction bits
`timescale 1ns/1ps
`include "tar_regs.svh"
module tar_ratio_div (
  input wire logic clk,
  input wire logic resetn,
  input wire logic start,
  input wire logic [15:0] num,
  input wire logic [15:0] den,
  output logic done,
  output logic [7:0] ratio
);
  import tar_pkg::*;
  tar_div_st_t st_reg;
  tar_div_st_t st_next;
  logic [16:0] diff;

  // ****************************************************************
  // next state: restoring division, msb (weight 1) first
  // ****************************************************************
  always_comb begin
    st_next = st_reg;
    diff = st_reg.rem - {1'b0, st_reg.den};
    case (st_reg.state)
      TAR_DIV_IDLE: begin
        if (start) begin
          st_next.den = den;
          st_next.rem = {1'b0, num};
          st_next.step = 4'h0;
          st_next.quot = 8'h00;
          // ratios of 2 or more, or a zero width, saturate
          if (den == 16'h0000 || {1'b0, num} >= {den, 1'b0}) begin
            st_next.quot = `TAR_RATIO_MAX;
            st_next.state = TAR_DIV_DONE;
          end else begin
            st_next.state = TAR_DIV_RUN;
          end
        end
      end
      TAR_DIV_RUN: begin
        if (!diff[16]) begin
          st_next.quot = {st_reg.quot[6:0], 1'b1};
          st_next.rem = {diff[15:0], 1'b0};
        end else begin
          st_next.quot = {st_reg.quot[6:0], 1'b0};
          st_next.rem = {st_reg.rem[15:0], 1'b0};
        end
        st_next.step = st_reg.step + 4'h1;
        if (st_reg.step == `TAR_DIV_STEPS - 4'h1) begin
          st_next.state = TAR_DIV_DONE;
        end
      end
      TAR_DIV_DONE: begin
        st_next.state = TAR_DIV_IDLE;
      end
      default: begin
        st_next.state = TAR_DIV_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign done = (st_reg.state == TAR_DIV_DONE);
  assign ratio = st_reg.quot;
endmodule

// [hdl/tar_bank.sv]
// tamper/alarm arm control register and upstream wave ratio result
`timescale 1ns/1ps
`include "tar_regs.svh"
// What this block does
// R1: results are read-only to the host, volatile, and never go to flash.
// R2: after reset every result register holds 0000h.
// R3: a tamper on the case switch pin sets the tamper arm bit with its flag, held until a host write of 0.
// R4: bits 7:0 of the wave ratio word hold second pulse width over ideal width.
// R5: the ideal width is half a period of the pulse launch frequency.
// R6: each ratio byte is unsigned fixed point, msb weighs 1, lsb 0.0078125.
// R7: an alarm match sets the alarm arm bit with its flag, held until a host write of 0.
// R8: the alarm match flag rises when the rtc time steps to the alarm setting.
// R9: the tamper event flag rises while the case switch pin is high.
module tar_bank (
  input wire logic clk,
  input wire logic resetn,
  input tar_pkg::tar_cmd_t host_cmd,
  output tar_pkg::tar_rsp_t host_rsp,
  input tar_pkg::tar_meas_t meas,
  input tar_pkg::tar_rtc_t rtc,
  input wire logic case_switch_input,
  output logic tamper_event_flag,
  output logic alarm_match_flag,
  output logic tamper_arm_bit,
  output logic alarm_arm_bit
);
  import tar_pkg::*;

  typedef struct packed {
    logic sw_meta;
    logic sw_sync;
    logic tamper_flag;
    logic alarm_flag;
    logic [15:0] ctrl;
    logic [15:0] upstream_wave_ratio;
    tar_rsp_t rsp;
  } tar_bank_st_t;

  tar_bank_st_t st_reg;
  tar_bank_st_t st_next;
  logic [1:0] div_done;
  logic [7:0] div_ratio [2];
  logic [15:0] div_num [2];
  logic match;
  logic ctrl_wr;

  // ****************************************************************
  // ratio dividers: [1] = t1 / t2 high byte, [0] = t2 / t_ideal low
  // ****************************************************************
  assign div_num[1] = meas.t1_width;
  assign div_num[0] = meas.t2_width;
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_div
      tar_ratio_div u_div (
        .clk(clk),
        .resetn(resetn),
        .start(meas.done),
        .num(div_num[gi]),
        // ideal width is half the launch period, see R5
        .den(gi == 0 ? meas.ideal_half_period : meas.t2_width),
        .done(div_done[gi]),
        .ratio(div_ratio[gi])
      );
    end
  endgenerate

  // alarm compare on the rtc step only, see R8
  assign match = rtc.tick && rtc.hours == rtc.alarm_hours
    && rtc.minutes == rtc.alarm_minutes;
  assign ctrl_wr = host_cmd.valid && host_cmd.opcode == `TAR_OP_CTRL_WR;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    st_next = st_reg;
    // pin is asynchronous: two flops before use
    st_next.sw_meta = case_switch_input;
    st_next.sw_sync = st_reg.sw_meta;
    st_next.tamper_flag = st_reg.sw_sync; // see R9
    st_next.alarm_flag = match;
    // host writes of 0 clear, 1 leaves alone; set wins over clear
    if (ctrl_wr) begin
      st_next.ctrl = st_reg.ctrl & host_cmd.wdata;
    end
    st_next.ctrl[15:10] = 6'h00;
    st_next.ctrl[7:0] = 8'h00;
    if (st_reg.sw_sync) begin
      st_next.ctrl[`TAR_CTRL_TAMPER_ARM_BIT] = 1'b1; // see R3
    end
    if (match) begin
      st_next.ctrl[`TAR_CTRL_ALARM_ARM_BIT] = 1'b1; // see R7
    end
    // results only load from the dividers, no host path, see R1
    // byte placement and 1.7 format, see R4 R6
    if (div_done[1]) begin
      st_next.upstream_wave_ratio[15:8] = div_ratio[1];
    end
    if (div_done[0]) begin
      st_next.upstream_wave_ratio[7:0] = div_ratio[0];
    end
    // read answers one cycle after the opcode
    st_next.rsp.valid = 1'b0;
    st_next.rsp.data = 16'h0000;
    if (host_cmd.valid) begin
      if (host_cmd.opcode == `TAR_OP_CTRL_RD) begin
        st_next.rsp.valid = 1'b1;
        st_next.rsp.data = st_reg.ctrl;
      end else if (host_cmd.opcode == `TAR_OP_WVR_RD) begin
        st_next.rsp.valid = 1'b1;
        st_next.rsp.data = st_reg.upstream_wave_ratio;
      end else if (!ctrl_wr) begin
        st_next.rsp.valid = 1'b1; // unknown opcode reads zero
      end
    end
  end

  // ****************************************************************
  // state register: everything clears at power-on, see R2
  // ****************************************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_reg <= '0;
      st_reg.ctrl <= `TAR_CTRL_RESET;
      st_reg.upstream_wave_ratio <= `TAR_RESULT_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from flops
  assign host_rsp = st_reg.rsp;
  assign tamper_event_flag = st_reg.tamper_flag;
  assign alarm_match_flag = st_reg.alarm_flag;
  assign tamper_arm_bit = st_reg.ctrl[`TAR_CTRL_TAMPER_ARM_BIT];
  assign alarm_arm_bit = st_reg.ctrl[`TAR_CTRL_ALARM_ARM_BIT];
endmodule

// [test/tar_bank_properties.sv]
// port timing checks for the tamper/alarm arm and ratio block
`timescale 1ns/1ps
module tar_bank_properties (
  input wire logic clk,
  input wire logic resetn,
  input tar_pkg::tar_cmd_t host_cmd,
  input tar_pkg::tar_rsp_t host_rsp,
  input tar_pkg::tar_meas_t meas,
  input tar_pkg::tar_rtc_t rtc,
  input wire logic case_switch_input,
  input wire logic tamper_event_flag,
  input wire logic alarm_match_flag,
  input wire logic tamper_arm_bit,
  input wire logic alarm_arm_bit
);
  import tar_pkg::*;
  // *****
  // checks
  // *****
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  logic wr, match;
  // decoded host write and a matching rtc step
  assign wr = host_cmd.valid && host_cmd.opcode == 8'hff;
  assign match = rtc.tick && rtc.hours == rtc.alarm_hours
    && rtc.minutes == rtc.alarm_minutes;
  read_answer_a: assert property (
    host_cmd.valid && !wr |=> host_rsp.valid) else $error("no answer");
  ctrl_read_a: assert property (
    host_cmd.valid && host_cmd.opcode == 8'h7f |=> host_rsp.data ==
    {6'h00, $past(alarm_arm_bit), $past(tamper_arm_bit), 8'h00})
    else $error("control read wrong");
  pin_high_a: assert property (
    case_switch_input [*5] |-> tamper_event_flag) else $error("flag low");
  pin_low_a: assert property (
    !case_switch_input [*5] |-> !tamper_event_flag) else $error("flag high");
  tamper_set_a: assert property (
    $rose(tamper_event_flag) |-> tamper_arm_bit) else $error("arm late");
  tamper_hold_a: assert property (
    tamper_arm_bit && !(wr && !host_cmd.wdata[8]) |=> tamper_arm_bit)
    else $error("tamper arm lost");
  alarm_set_a: assert property (
    match |=> alarm_match_flag && alarm_arm_bit) else $error("no alarm");
  alarm_cause_a: assert property (
    alarm_match_flag |-> $past(match)) else $error("stray alarm");
  alarm_hold_a: assert property (
    $fell(alarm_arm_bit) |-> $past(wr) && !$past(host_cmd.wdata[9]))
    else $error("alarm arm lost");
endmodule

bind tar_bank tar_bank_properties i_props (.clk(clk), .resetn(resetn),
  .host_cmd(host_cmd), .host_rsp(host_rsp), .meas(meas), .rtc(rtc),
  .case_switch_input(case_switch_input),
  .tamper_event_flag(tamper_event_flag),
  .alarm_match_flag(alarm_match_flag), .tamper_arm_bit(tamper_arm_bit),
  .alarm_arm_bit(alarm_arm_bit));

// [test/tb.sv]
// self-checking bench for the tamper/alarm arm and ratio block
`timescale 1ns/1ps
module tb;
  import tar_pkg::*;
  logic clk, resetn, case_switch_input;
  tar_cmd_t host_cmd;
  tar_rsp_t host_rsp;
  tar_meas_t meas;
  tar_rtc_t rtc;
  logic tamper_event_flag, alarm_match_flag, tamper_arm_bit, alarm_arm_bit;
  int fail_count = 0;
  int cmp_count = 0;
  logic [15:0] d;
  tar_bank i_dut (.clk(clk), .resetn(resetn), .host_cmd(host_cmd),
    .host_rsp(host_rsp), .meas(meas), .rtc(rtc),
    .case_switch_input(case_switch_input),
    .tamper_event_flag(tamper_event_flag),
    .alarm_match_flag(alarm_match_flag), .tamper_arm_bit(tamper_arm_bit),
    .alarm_arm_bit(alarm_arm_bit));
  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // one command; a missing answer leaves d unknown so it never matches
  task cmd(input logic [7:0] op, input logic [15:0] wd);
    @(posedge clk);
    host_cmd <= '{1'b1, op, wd};
    @(posedge clk);
    host_cmd <= '0;
    #1 d = host_rsp.valid ? host_rsp.data : 16'hxxxx;
  endtask
  // order: event flag, match flag, tamper arm, alarm arm
  task flags(input logic [3:0] exp);
    chk(16'({tamper_event_flag, alarm_match_flag, tamper_arm_bit,
      alarm_arm_bit}), 16'(exp));
  endtask
  task t_reset;
    flags(4'h0);
    cmd(8'h7f, 16'h0000);
    chk(d, 16'h0000);
    cmd(8'hc4, 16'h0000);
    chk(d, 16'h0000);
    cmd(8'h00, 16'h0000);
    chk(d, 16'h0000);
    $display("reset test done");
  endtask
  // a write in between must not disturb the result word
  task t_ratio(input logic [15:0] t1, t2, ti, exp);
    @(posedge clk);
    meas <= '{1'b1, t1, t2, ti};
    @(posedge clk);
    meas.done <= 1'b0;
    repeat (12) @(posedge clk);
    cmd(8'hc4, 16'h0000);
    chk(d, exp);
    cmd(8'hff, 16'hffff);
    cmd(8'hc4, 16'h0000);
    chk(d, exp);
    $display("ratio test done");
  endtask
  task t_tamper;
    cmd(8'hff, 16'h0300);
    flags(4'h0);
    @(posedge clk);
    case_switch_input <= 1'b1;
    repeat (5) @(posedge clk);
    #1 flags(4'ha);
    cmd(8'hff, 16'h0000);
    flags(4'ha);
    @(posedge clk);
    case_switch_input <= 1'b0;
    repeat (5) @(posedge clk);
    #1 flags(4'h2);
    cmd(8'h7f, 16'h0000);
    chk(d, 16'h0100);
    cmd(8'hff, 16'h0000);
    flags(4'h0);
    $display("tamper test done");
  endtask
  task t_alarm;
    @(posedge clk);
    rtc <= '{1'b1, 8'h0a, 8'h1e, 8'h0a, 8'h1f};
    @(posedge clk);
    rtc.tick <= 1'b0;
    #1 flags(4'h0);
    @(posedge clk);
    rtc <= '{1'b1, 8'h0a, 8'h1f, 8'h0a, 8'h1f};
    @(posedge clk);
    rtc.tick <= 1'b0;
    #1 flags(4'h5);
    cmd(8'h7f, 16'h0000);
    chk(d, 16'h0200);
    cmd(8'hff, 16'h0000);
    flags(4'h0);
    $display("alarm test done");
  endtask
  task complete_run;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // main sequence
  initial begin
    resetn = 1'b0;
    case_switch_input = 1'b0;
    host_cmd = '0;
    meas = '0;
    rtc = '0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    t_reset;
    t_ratio(16'h00e1, 16'h0096, 16'h00c8, 16'hc060);
    t_ratio(16'h0064, 16'h00c8, 16'h0320, 16'h4020);
    t_ratio(16'h00ff, 16'h0080, 16'h0000, 16'hffff);
    // mid-run reset must wipe the loaded result word
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    t_reset;
    t_tamper;
    t_alarm;
    complete_run;
  end
  // watchdog, far beyond the roughly 105 cycles the tests need
  initial begin
    #50000;
    fail_count++;
    complete_run;
  end
endmodule
